// *** design/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // byte offsets of the register map
  localparam logic [6:0] OFS_STATUS = 7'h00;
  localparam logic [6:0] OFS_CTRL_ONE = 7'h04;
  localparam logic [6:0] OFS_CTRL_TWO = 7'h08;
  localparam logic [6:0] OFS_SMP_ONE = 7'h0c;
  localparam logic [6:0] OFS_SMP_TWO = 7'h10;
  localparam logic [6:0] OFS_INJ_OFF = 7'h14;
  localparam logic [6:0] OFS_INJ_OFF_LAST = 7'h20;
  localparam logic [6:0] OFS_WD_HIGH = 7'h24;
  localparam logic [6:0] OFS_WD_LOW = 7'h28;
  localparam logic [6:0] OFS_SEQ_ONE = 7'h2c;
  localparam logic [6:0] OFS_SEQ_TWO = 7'h30;
  localparam logic [6:0] OFS_SEQ_THREE = 7'h34;
  localparam logic [6:0] OFS_INJ_SEQ = 7'h38;
  localparam logic [6:0] OFS_INJ_RES = 7'h3c;
  localparam logic [6:0] OFS_INJ_RES_LAST = 7'h48;
  localparam logic [6:0] OFS_REG_RES = 7'h4c;

  // status bit positions
  localparam int BIT_WINDOW_FLAG = 0;
  localparam int BIT_REG_DONE = 1;
  localparam int BIT_INJ_DONE = 2;
  localparam int BIT_INJ_STARTED = 3;
  localparam int BIT_REG_STARTED = 4;
  localparam int STATUS_BITS = 5;

  // control one fields
  localparam int BIT_REG_DONE_IEN = 5;
  localparam int BIT_WINDOW_IEN = 6;
  localparam int BIT_INJ_DONE_IEN = 7;
  localparam int POS_DUAL_MODE = 16;
  localparam int DUAL_MODE_BITS = 4;

  // control two fields
  localparam int BIT_DMA_ENABLE = 8;
  localparam int BIT_ALIGN_LEFT = 11;
  localparam int POS_INJ_TRIG_SEL = 12;
  localparam int POS_REG_TRIG_SEL = 17;
  localparam int BIT_INJ_SW_START = 21;
  localparam int BIT_REG_SW_START = 22;
  localparam int BIT_REG_ALT_SRC = 24;
  localparam int BIT_INJ_ALT_SRC = 25;

  // trigger select codes
  localparam logic [2:0] TRIG_ALT_CODE = 3'h6;
  localparam logic [2:0] TRIG_SW_CODE = 3'h7;

  // converter data
  localparam int RAW_BITS = 12;
  localparam int RES_BITS = 16;

  // reset values
  localparam logic [STATUS_BITS-1:0] STATUS_RST = 5'h00;
  localparam logic [31:0] CTRL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_TWO_RST = 32'h0000_0000;
  localparam logic [31:0] WD_HIGH_RST = 32'h0000_0fff;
  localparam logic [31:0] REG_ZERO_RST = 32'h0000_0000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** design/adc_trigger_result_flags.sv ***
`timescale 1ns/1ps
module adc_trigger_result_flags #(
  parameter int unsigned CONV_INDEX = 1
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [6:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [6:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [6:0] REG_TRIG_TIMERS,
  input wire logic [6:0] INJ_TRIG_TIMERS,
  input wire logic EXT_LINE_11,
  input wire logic EXT_LINE_15,
  output logic REG_START,
  output logic INJ_START,
  input wire logic REG_DONE,
  input wire logic [11:0] REG_VALUE,
  input wire logic [11:0] SLAVE_VALUE,
  input wire logic INJ_DONE,
  input wire logic [11:0] INJ_VALUE,
  input wire logic [1:0] INJ_RANK,
  output logic DMA_REQ,
  output logic IRQ
);
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_hold;
    logic w_hold;
    logic [6:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [1:0] r_resp;
    logic [31:0] r_data;
    logic [adc_ctrl_pkg::STATUS_BITS-1:0] status;
    logic [31:0] ctrl1;
    logic [31:0] ctrl2;
    logic [31:0] smp1;
    logic [31:0] smp2;
    logic [3:0][31:0] inj_off;
    logic [31:0] wd_high;
    logic [31:0] wd_low;
    logic [31:0] seq1;
    logic [31:0] seq2;
    logic [31:0] seq3;
    logic [31:0] inj_seq;
    logic [3:0][15:0] inj_res;
    logic [31:0] reg_res;
    logic [6:0] reg_src_q;
    logic [6:0] inj_src_q;
    logic reg_start;
    logic inj_start;
    logic dma_req;
    logic irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic line11_rise;
  logic line15_rise;

  // external lines come from pins, so they are synchronised first
  pin_rise_sync line11_sync (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .pin(EXT_LINE_11),
    .level(),
    .rise(line11_rise)
  );

  pin_rise_sync line15_sync (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .pin(EXT_LINE_15),
    .level(),
    .rise(line15_rise)
  );

  // place a raw sample in the 16-bit field
  function automatic logic [15:0] align_raw(input logic left,
                                            input logic [11:0] v);
    if (left) begin
      align_raw = {v, 4'h0};
    end else begin
      align_raw = {4'h0, v};
    end
  endfunction

  // true when the sample lies outside the programmed window
  function automatic logic outside(input logic [11:0] v,
                                   input logic [31:0] hi,
                                   input logic [31:0] lo);
    outside = (v > hi[11:0]) || (v < lo[11:0]);
  endfunction

  // register read decode; unmapped offsets answer an error
  function automatic logic [33:0] read_word(input state_t s,
                                            input logic [6:0] a);
    logic [6:0] rel;
    read_word = {adc_ctrl_pkg::RESP_OKAY, 32'h0000_0000};
    rel = 7'h00;
    if (a[1:0] != 2'h0) begin
      read_word = {adc_ctrl_pkg::RESP_SLVERR, 32'h0000_0000};
    end else if (a >= adc_ctrl_pkg::OFS_INJ_OFF &&
                 a <= adc_ctrl_pkg::OFS_INJ_OFF_LAST) begin
      rel = a - adc_ctrl_pkg::OFS_INJ_OFF;
      read_word[31:0] = s.inj_off[rel[3:2]];
    end else if (a >= adc_ctrl_pkg::OFS_INJ_RES &&
                 a <= adc_ctrl_pkg::OFS_INJ_RES_LAST) begin
      rel = a - adc_ctrl_pkg::OFS_INJ_RES;
      read_word[31:0] = {16'h0000, s.inj_res[rel[3:2]]};
    end else begin
      case (a)
        adc_ctrl_pkg::OFS_STATUS: begin
          read_word[31:0] = {27'h0, s.status};
        end
        adc_ctrl_pkg::OFS_CTRL_ONE: read_word[31:0] = s.ctrl1;
        adc_ctrl_pkg::OFS_CTRL_TWO: read_word[31:0] = s.ctrl2;
        adc_ctrl_pkg::OFS_SMP_ONE: read_word[31:0] = s.smp1;
        adc_ctrl_pkg::OFS_SMP_TWO: read_word[31:0] = s.smp2;
        adc_ctrl_pkg::OFS_WD_HIGH: read_word[31:0] = s.wd_high;
        adc_ctrl_pkg::OFS_WD_LOW: read_word[31:0] = s.wd_low;
        adc_ctrl_pkg::OFS_SEQ_ONE: read_word[31:0] = s.seq1;
        adc_ctrl_pkg::OFS_SEQ_TWO: read_word[31:0] = s.seq2;
        adc_ctrl_pkg::OFS_SEQ_THREE: read_word[31:0] = s.seq3;
        adc_ctrl_pkg::OFS_INJ_SEQ: read_word[31:0] = s.inj_seq;
        adc_ctrl_pkg::OFS_REG_RES: read_word[31:0] = s.reg_res;
        default: begin
          read_word = {adc_ctrl_pkg::RESP_SLVERR, 32'h0000_0000};
        end
      endcase
    end
  endfunction

  // byte-lane merge for plain read-write registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction

  logic [2:0] reg_sel;
  logic [2:0] inj_sel;
  logic [6:0] reg_edge;
  logic [6:0] inj_edge;
  logic reg_fire;
  logic inj_fire;
  logic left;
  logic dual;
  logic [33:0] rd;
  logic [6:0] rel_w;
  logic [adc_ctrl_pkg::STATUS_BITS-1:0] st_set;

  // trigger selection, bus slave, results and flags
  always_comb begin
    s_nxt = s_r;
    rel_w = 7'h00;
    rd = 34'h0_0000_0000;
    reg_sel = s_r.ctrl2[adc_ctrl_pkg::POS_REG_TRIG_SEL +: 3];
    inj_sel = s_r.ctrl2[adc_ctrl_pkg::POS_INJ_TRIG_SEL +: 3];
    left = s_r.ctrl2[adc_ctrl_pkg::BIT_ALIGN_LEFT];
    dual = (CONV_INDEX == 1) &&
           (s_r.ctrl1[adc_ctrl_pkg::POS_DUAL_MODE +:
                      adc_ctrl_pkg::DUAL_MODE_BITS] != 4'h0);
    // a source counts only on its rising edge
    reg_edge = REG_TRIG_TIMERS & ~s_r.reg_src_q;
    inj_edge = INJ_TRIG_TIMERS & ~s_r.inj_src_q;
    s_nxt.reg_src_q = REG_TRIG_TIMERS;
    s_nxt.inj_src_q = INJ_TRIG_TIMERS;

    // converter 3 ignores the alternate pin sources
    if (reg_sel == adc_ctrl_pkg::TRIG_SW_CODE) begin
      reg_fire = s_r.ctrl2[adc_ctrl_pkg::BIT_REG_SW_START];
    end else if (reg_sel == adc_ctrl_pkg::TRIG_ALT_CODE && CONV_INDEX != 3 &&
                 s_r.ctrl2[adc_ctrl_pkg::BIT_REG_ALT_SRC]) begin
      reg_fire = line11_rise;
    end else begin
      reg_fire = reg_edge[reg_sel];
    end
    if (inj_sel == adc_ctrl_pkg::TRIG_SW_CODE) begin
      inj_fire = s_r.ctrl2[adc_ctrl_pkg::BIT_INJ_SW_START];
    end else if (inj_sel == adc_ctrl_pkg::TRIG_ALT_CODE && CONV_INDEX != 3 &&
                 s_r.ctrl2[adc_ctrl_pkg::BIT_INJ_ALT_SRC]) begin
      inj_fire = line15_rise;
    end else begin
      inj_fire = inj_edge[inj_sel];
    end
    s_nxt.reg_start = reg_fire;
    s_nxt.inj_start = inj_fire;
    // software start bits drop once the conversion is launched
    if (reg_fire && reg_sel == adc_ctrl_pkg::TRIG_SW_CODE) begin
      s_nxt.ctrl2[adc_ctrl_pkg::BIT_REG_SW_START] = 1'b0;
    end
    if (inj_fire && inj_sel == adc_ctrl_pkg::TRIG_SW_CODE) begin
      s_nxt.ctrl2[adc_ctrl_pkg::BIT_INJ_SW_START] = 1'b0;
    end

    // results: one shared regular word, one word per injected rank
    if (REG_DONE) begin
      if (dual) begin
        s_nxt.reg_res = {align_raw(left, SLAVE_VALUE),
                         align_raw(left, REG_VALUE)};
      end else begin
        s_nxt.reg_res = {16'h0000, align_raw(left, REG_VALUE)};
      end
    end
    if (INJ_DONE) begin
      s_nxt.inj_res[INJ_RANK] = align_raw(left, INJ_VALUE);
    end

    // hardware set sources for the status flags
    st_set = '0;
    st_set[adc_ctrl_pkg::BIT_REG_DONE] = REG_DONE;
    st_set[adc_ctrl_pkg::BIT_INJ_DONE] = INJ_DONE;
    st_set[adc_ctrl_pkg::BIT_WINDOW_FLAG] =
      (REG_DONE && outside(REG_VALUE, s_r.wd_high, s_r.wd_low)) ||
      (INJ_DONE && outside(INJ_VALUE, s_r.wd_high, s_r.wd_low));
    st_set[adc_ctrl_pkg::BIT_INJ_STARTED] = inj_fire;
    st_set[adc_ctrl_pkg::BIT_REG_STARTED] = reg_fire;

    // dma: converter 2 hands its data over through converter 1
    s_nxt.dma_req = REG_DONE && (CONV_INDEX != 2) &&
                    s_r.ctrl2[adc_ctrl_pkg::BIT_DMA_ENABLE];

    // write address and data are taken in either order
    if (AWVALID && s_r.aw_rdy) begin
      s_nxt.aw_addr = AWADDR;
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_rdy = 1'b0;
    end
    if (WVALID && s_r.w_rdy) begin
      s_nxt.wdata = WDATA;
      s_nxt.wstrb = WSTRB;
      s_nxt.w_hold = 1'b1;
      s_nxt.w_rdy = 1'b0;
    end
    if (s_r.aw_hold && s_r.w_hold && !s_r.b_valid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.b_valid = 1'b1;
      s_nxt.b_resp = adc_ctrl_pkg::RESP_OKAY;
      if (s_r.aw_addr[1:0] != 2'h0) begin
        s_nxt.b_resp = adc_ctrl_pkg::RESP_SLVERR;
      end else if (s_r.aw_addr >= adc_ctrl_pkg::OFS_INJ_OFF &&
                   s_r.aw_addr <= adc_ctrl_pkg::OFS_INJ_OFF_LAST) begin
        rel_w = s_r.aw_addr - adc_ctrl_pkg::OFS_INJ_OFF;
        s_nxt.inj_off[rel_w[3:2]] = merge(s_r.inj_off[rel_w[3:2]],
                                          s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_addr >= adc_ctrl_pkg::OFS_INJ_RES &&
                   s_r.aw_addr <= adc_ctrl_pkg::OFS_INJ_RES_LAST) begin
        s_nxt.b_resp = adc_ctrl_pkg::RESP_OKAY; // read-only, write dropped
      end else begin
        case (s_r.aw_addr)
          adc_ctrl_pkg::OFS_STATUS: begin
            // writing 0 clears, writing 1 keeps
            if (s_r.wstrb[0]) begin
              s_nxt.status = s_r.status &
                             s_r.wdata[adc_ctrl_pkg::STATUS_BITS-1:0];
            end
          end
          adc_ctrl_pkg::OFS_CTRL_ONE: begin
            s_nxt.ctrl1 = merge(s_r.ctrl1, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_CTRL_TWO: begin
            // a fresh write wins over the same-cycle self-clear
            s_nxt.ctrl2 = merge(s_r.ctrl2, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_SMP_ONE: begin
            s_nxt.smp1 = merge(s_r.smp1, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_SMP_TWO: begin
            s_nxt.smp2 = merge(s_r.smp2, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_WD_HIGH: begin
            s_nxt.wd_high = merge(s_r.wd_high, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_WD_LOW: begin
            s_nxt.wd_low = merge(s_r.wd_low, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_SEQ_ONE: begin
            s_nxt.seq1 = merge(s_r.seq1, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_SEQ_TWO: begin
            s_nxt.seq2 = merge(s_r.seq2, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_SEQ_THREE: begin
            s_nxt.seq3 = merge(s_r.seq3, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_INJ_SEQ: begin
            s_nxt.inj_seq = merge(s_r.inj_seq, s_r.wdata, s_r.wstrb);
          end
          adc_ctrl_pkg::OFS_REG_RES: begin
            s_nxt.b_resp = adc_ctrl_pkg::RESP_OKAY;
          end
          default: begin
            s_nxt.b_resp = adc_ctrl_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // set wins over a clear arriving in the same cycle
    s_nxt.status = s_nxt.status | st_set;
    if (s_r.b_valid && BREADY) begin
      s_nxt.b_valid = 1'b0;
      s_nxt.aw_rdy = 1'b1;
      s_nxt.w_rdy = 1'b1;
    end

    // read channel: one read at a time, data held until taken
    if (ARVALID && s_r.ar_rdy) begin
      rd = read_word(s_r, ARADDR);
      s_nxt.r_data = rd[31:0];
      s_nxt.r_resp = rd[33:32];
      s_nxt.r_valid = 1'b1;
      s_nxt.ar_rdy = 1'b0;
    end
    if (s_r.r_valid && RREADY) begin
      s_nxt.r_valid = 1'b0;
      s_nxt.ar_rdy = 1'b1;
    end

    // one shared line, each source gated by its enable
    s_nxt.irq =
      (s_r.status[adc_ctrl_pkg::BIT_REG_DONE] &
       s_r.ctrl1[adc_ctrl_pkg::BIT_REG_DONE_IEN]) |
      (s_r.status[adc_ctrl_pkg::BIT_WINDOW_FLAG] &
       s_r.ctrl1[adc_ctrl_pkg::BIT_WINDOW_IEN]) |
      (s_r.status[adc_ctrl_pkg::BIT_INJ_DONE] &
       s_r.ctrl1[adc_ctrl_pkg::BIT_INJ_DONE_IEN]);
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r <= '0;
      s_r.aw_rdy <= 1'b1;
      s_r.w_rdy <= 1'b1;
      s_r.ar_rdy <= 1'b1;
      s_r.status <= adc_ctrl_pkg::STATUS_RST;
      s_r.ctrl1 <= adc_ctrl_pkg::CTRL_ONE_RST;
      s_r.ctrl2 <= adc_ctrl_pkg::CTRL_TWO_RST;
      s_r.wd_high <= adc_ctrl_pkg::WD_HIGH_RST;
      s_r.wd_low <= adc_ctrl_pkg::REG_ZERO_RST;
      s_r.reg_res <= adc_ctrl_pkg::REG_ZERO_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a flip-flop of the state record
  assign AWREADY = s_r.aw_rdy;
  assign WREADY = s_r.w_rdy;
  assign BVALID = s_r.b_valid;
  assign BRESP = s_r.b_resp;
  assign ARREADY = s_r.ar_rdy;
  assign RVALID = s_r.r_valid;
  assign RDATA = s_r.r_data;
  assign RRESP = s_r.r_resp;
  assign REG_START = s_r.reg_start;
  assign INJ_START = s_r.inj_start;
  assign DMA_REQ = s_r.dma_req;
  assign IRQ = s_r.irq;
endmodule

// *** design/pin_rise_sync.sv ***
`timescale 1ns/1ps
// three-stage pin synchroniser with a filtered level and rising-edge pulse
module pin_rise_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  typedef struct packed {
    logic m1;
    logic m2;
    logic m3;
    logic lvl;
    logic rise;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  // level moves only when the second and third stages agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.m1 = pin;
    s_nxt.m2 = s_r.m1;
    s_nxt.m3 = s_r.m2;
    s_nxt.rise = 1'b0;
    if (s_r.m2 == s_r.m3) begin
      s_nxt.lvl = s_r.m3;
      s_nxt.rise = s_r.m3 & ~s_r.lvl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;
  assign rise = s_r.rise;
endmodule

// *** tb/adc_ctrl_properties.sv ***
`timescale 1ns/1ps
// watches the bus handshakes and the start, done and dma strobes
module adc_ctrl_properties #(
  parameter int unsigned CONV_INDEX = 1
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic REG_START,
  input wire logic INJ_START,
  input wire logic REG_DONE,
  input wire logic DMA_REQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  // address and data taken together, and a read address taken
  sequence aw_w_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence ar_take;
    ARVALID && ARREADY;
  endsequence

  write_answer_a: assert property (aw_w_take |-> ##2 BVALID)
    else $error("write response late");
  write_busy_a: assert property (aw_w_take |=> !AWREADY && !WREADY)
    else $error("write channel ready while busy");
  bresp_hold_a: assert property (BVALID && !BREADY |=>
    BVALID && $stable(BRESP))
    else $error("write response dropped early");
  read_answer_a: assert property (ar_take |=> RVALID && !ARREADY)
    else $error("read data late");
  rdata_hold_a: assert property (RVALID && !RREADY |=>
    RVALID && $stable(RDATA))
    else $error("read data changed before taken");
  reg_start_pulse_a: assert property (REG_START |=> !REG_START)
    else $error("regular start longer than one cycle");
  inj_start_pulse_a: assert property (INJ_START |=> !INJ_START)
    else $error("injected start longer than one cycle");
  dma_cause_a: assert property (DMA_REQ |-> $past(REG_DONE))
    else $error("dma request without regular result");
  dma_single_a: assert property (DMA_REQ |=> !DMA_REQ)
    else $error("dma request longer than one cycle");
  dma_conv_two_a: assert property (DMA_REQ |-> CONV_INDEX != 2)
    else $error("dma request from second converter");
endmodule

bind adc_trigger_result_flags adc_ctrl_properties #(
  .CONV_INDEX(CONV_INDEX)
) props (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .REG_START(REG_START),
  .INJ_START(INJ_START), .REG_DONE(REG_DONE), .DMA_REQ(DMA_REQ));

// *** tb/conv_far_model.sv ***
`timescale 1ns/1ps
// converter core stand-in: answers each start lat+1 cycles after it is sampled
module conv_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic reg_start,
  input wire logic inj_start,
  input wire logic [11:0] val_in,
  input wire logic [11:0] slv_in,
  input wire logic [1:0] rank_in,
  output logic reg_done,
  output logic inj_done,
  output logic [11:0] value,
  output logic [11:0] slave,
  output logic [1:0] rank
);
  logic [4:0] rcnt_r;
  logic [4:0] icnt_r;
  // data lines toggle outside a done pulse so stale values never match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_r <= '0;
      icnt_r <= '0;
      reg_done <= 1'b0;
      inj_done <= 1'b0;
      value <= '0;
      slave <= '0;
      rank <= '0;
    end else begin
      rcnt_r <= reg_start ? {1'b0, lat} + 5'h1 : rcnt_r - 5'(rcnt_r != 0);
      icnt_r <= inj_start ? {1'b0, lat} + 5'h1 : icnt_r - 5'(icnt_r != 0);
      reg_done <= (rcnt_r == 5'h1);
      inj_done <= (icnt_r == 5'h1);
      value <= (rcnt_r == 5'h1 || icnt_r == 5'h1) ? val_in : ~value;
      slave <= (rcnt_r == 5'h1) ? slv_in : ~slave;
      rank <= (icnt_r == 5'h1) ? rank_in : ~rank;
    end
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, ext11 = 0, ext15 = 0;
  logic [6:0] awaddr = '0, araddr = '0, reg_tmr = '0, inj_tmr = '0;
  logic [31:0] wdata = '0, seed = 32'h0da19571;
  logic [3:0] wstrb = 4'hf, lat = 4'h2;
  logic [11:0] val = '0, slv = '0, exp_inj[4];
  logic [1:0] rank_in = '0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, DMA_REQ, IRQ;
  wire REG_START, INJ_START, REG_DONE, INJ_DONE;
  wire [1:0] BRESP, RRESP, INJ_RANK;
  wire [31:0] RDATA;
  wire [11:0] VALUE, SLAVE;
  int miscompares = 0, n_compared = 0, n_done = 0, n_start = 0, n_dma = 0;

  always #4 clk = ~clk;
  // strobe counters let the scenarios wait with a bound
  always @(posedge clk) begin
    n_done += int'(REG_DONE) + int'(INJ_DONE);
    n_start += int'(REG_START) + int'(INJ_START);
    n_dma += int'(DMA_REQ);
  end

  adc_trigger_result_flags #(.CONV_INDEX(1)) uut (.SYS_CLK(clk),
    .RSTN(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(AWREADY),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(rready), .REG_TRIG_TIMERS(reg_tmr),
    .INJ_TRIG_TIMERS(inj_tmr), .EXT_LINE_11(ext11), .EXT_LINE_15(ext15),
    .REG_START(REG_START), .INJ_START(INJ_START), .REG_DONE(REG_DONE),
    .REG_VALUE(VALUE), .SLAVE_VALUE(SLAVE), .INJ_DONE(INJ_DONE),
    .INJ_VALUE(VALUE), .INJ_RANK(INJ_RANK), .DMA_REQ(DMA_REQ), .IRQ(IRQ));

  conv_far_model far (.clk(clk), .rst_n(rst_n), .lat(lat),
    .reg_start(REG_START), .inj_start(INJ_START), .val_in(val),
    .slv_in(slv), .rank_in(rank_in), .reg_done(REG_DONE),
    .inj_done(INJ_DONE), .value(VALUE), .slave(SLAVE), .rank(INJ_RANK));

  int n_st[2:3] = '{0, 0}, n_dm[2:3] = '{0, 0};
  // converters 2 and 3 see every input of the first: only alternate pin sources, dual mode and dma
  // differ, so their start and dma counts are checked at the end
  for (genvar j = 2; j < 4; j++) begin : other
    wire st_r, st_i, dm;
    adc_trigger_result_flags #(.CONV_INDEX(j)) uut (.SYS_CLK(clk),
      .RSTN(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(),
      .BRESP(), .BVALID(), .BREADY(bready), .ARADDR(araddr),
      .ARVALID(arvalid), .ARREADY(), .RDATA(), .RRESP(), .RVALID(),
      .RREADY(rready), .REG_TRIG_TIMERS(reg_tmr), .INJ_TRIG_TIMERS(inj_tmr),
      .EXT_LINE_11(ext11), .EXT_LINE_15(ext15), .REG_START(st_r),
      .INJ_START(st_i), .REG_DONE(REG_DONE), .REG_VALUE(VALUE),
      .SLAVE_VALUE(SLAVE), .INJ_DONE(INJ_DONE), .INJ_VALUE(VALUE),
      .INJ_RANK(INJ_RANK), .DMA_REQ(dm), .IRQ());
    always @(posedge clk) begin
      n_st[j] += int'(st_r) + int'(st_i);
      n_dm[j] += int'(dm);
    end
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // control two word: select field, remap, software start, align, dma
  function automatic logic [31:0] ctl2(input int g, input int c,
                                       input bit left, input bit dma);
    logic [31:0] w;
    w = 32'h0;
    w[(g != 0 ? 12 : 17) +: 3] = c[2:0];
    w[g != 0 ? 25 : 24] = (c == 6);
    w[g != 0 ? 21 : 22] = (c == 7);
    w[11] = left;
    w[8] = dma;
    return w;
  endfunction

  task results();
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task fail(input string m);
    miscompares++;
    $display("ERROR %0t: %s", $time, m);
    results();
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [6:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && AWREADY) awvalid <= 1'b0;
      if (wvalid && WREADY) wvalid <= 1'b0;
      if (BVALID && bready) break;
      if (BVALID) bready <= 1'b1;
    end
    if (i == 50) fail("write timeout");
    bready <= 1'b0;
    chk(BRESP, adc_ctrl_pkg::RESP_OKAY);
  endtask

  task rd(input logic [6:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && ARREADY) arvalid <= 1'b0;
      if (RVALID && rready) break;
      if (RVALID) rready <= 1'b1;
    end
    if (i == 50) fail("read timeout");
    rready <= 1'b0;
    chk(RDATA, e);
    chk(RRESP, er);
  endtask

  // a two-cycle pulse on a timer bit, or on the pin when b is 7
  task trig(input int g, input int b);
    @(posedge clk);
    if (b == 7) begin
      if (g != 0) ext15 <= 1'b1;
      else ext11 <= 1'b1;
    end else if (g != 0) inj_tmr[b] <= 1'b1;
    else reg_tmr[b] <= 1'b1;
    repeat (2) @(posedge clk);
    ext11 <= 1'b0; ext15 <= 1'b0; reg_tmr <= '0; inj_tmr <= '0;
  endtask

  task wait_done(input int t);
    int i;
    for (i = 0; i < 100 && n_done < t; i++) @(posedge clk);
    if (n_done < t) fail("conversion missing");
  endtask

  initial begin
    int g, c, k, exp_done;
    logic [31:0] r;
    exp_done = 0;
    // injected result words reset to zero, so every rank is checked
    for (k = 0; k < 4; k++) exp_inj[k] = 12'h000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(adc_ctrl_pkg::OFS_STATUS, 32'h0, 2'h0);
    rd(adc_ctrl_pkg::OFS_CTRL_TWO, 32'h0, 2'h0);
    rd(adc_ctrl_pkg::OFS_WD_HIGH, 32'hfff, 2'h0);
    rd(7'h50, 32'h0, adc_ctrl_pkg::RESP_SLVERR);
    rd(7'h06, 32'h0, adc_ctrl_pkg::RESP_SLVERR);
    wr(adc_ctrl_pkg::OFS_REG_RES, 32'hffffffff);
    rd(adc_ctrl_pkg::OFS_REG_RES, 32'h0, 2'h0);
    wr(adc_ctrl_pkg::OFS_WD_HIGH, 32'h800);
    wr(adc_ctrl_pkg::OFS_WD_LOW, 32'h100);
    // software start inside the window, then outside it left aligned
    for (k = 0; k < 3; k++) begin
      r = rnd();
      val <= (k == 1) ? 12'h900 | r[7:0] : 12'h100 + r[9:0];
      slv <= r[27:16];
      lat <= r[31:28];
      wr(adc_ctrl_pkg::OFS_CTRL_ONE, k == 2 ? 32'h10000 : 32'h40);
      wr(adc_ctrl_pkg::OFS_CTRL_TWO, ctl2(0, 7, k == 1, 1));
      wait_done(++exp_done);
      rd(adc_ctrl_pkg::OFS_STATUS, k == 1 ? 32'h13 : 32'h12, 2'h0);
      rd(adc_ctrl_pkg::OFS_CTRL_TWO, ctl2(0, 0, k == 1, 1) | 32'he0000,
         2'h0);
      rd(adc_ctrl_pkg::OFS_REG_RES, k == 2 ? {4'h0, slv, 4'h0, val} :
         k == 1 ? {16'h0, val, 4'h0} : {20'h0, val}, 2'h0);
      chk(IRQ, k == 1);
      wr(adc_ctrl_pkg::OFS_STATUS, 32'hfffffffd);
      rd(adc_ctrl_pkg::OFS_STATUS, k == 1 ? 32'h11 : 32'h10, 2'h0);
      wr(adc_ctrl_pkg::OFS_STATUS, 32'h0);
      rd(adc_ctrl_pkg::OFS_STATUS, 32'h0, 2'h0);
      chk(IRQ, 0);
    end
    wr(adc_ctrl_pkg::OFS_CTRL_ONE, 32'h0);
    // every select code of both groups, a wrong source pulsed first for codes 0 to 6
    for (g = 0; g < 2; g++) begin
      for (c = 0; c < 8; c++) begin
        r = rnd();
        val <= 12'h100 + r[9:0];
        rank_in <= r[13:12];
        lat <= r[19:16];
        wr(adc_ctrl_pkg::OFS_CTRL_TWO, ctl2(g, c, 0, 0));
        if (c < 7) trig(g, c < 6 ? c + 1 : 6);
        if (c < 7) trig(g, c < 6 ? c : 7);
        wait_done(++exp_done);
        if (g == 0) rd(adc_ctrl_pkg::OFS_REG_RES, {20'h0, val}, 2'h0);
        else exp_inj[rank_in] = val;
      end
    end
    for (k = 0; k < 4; k++) begin
      rd(adc_ctrl_pkg::OFS_INJ_RES + {k[2:0], 2'b00},
         {20'h0, exp_inj[k]}, 2'h0);
    end
    rd(adc_ctrl_pkg::OFS_STATUS, 32'h1e, 2'h0);
    chk(n_start, exp_done);
    chk(n_dma, 3);
    chk(n_st[2], exp_done);
    chk(n_st[3], exp_done);
    chk(n_dm[2], 0);
    chk(n_dm[3], 3);
    results();
  end
endmodule
